// ### hw/crc_readout_defs.svh
// constants for the signature readout port and the integrity checker
`ifndef CRC_READOUT_DEFS_SVH
`define CRC_READOUT_DEFS_SVH

// signature width and reset contents
`define SIG_W           32
`define SIG_RST         32'h0000_0000

// serial readout: further clocks after a load to walk the whole word
`define SHIFT_TAIL      31
`define SHIFT_CNT_W     5

// shift-not-load must stay low for this many readout edges; the port already loads on a single one
`define LOAD_LOW_MIN    2

// check clock: oscillator divided by two to the power n, n in 0..8; the checker divides sys_clk instead
`define OSC_FREQ_MHZ    80
`define SYS_FREQ_MHZ    100
`define DIV_EXP_MAX     8
`define DIV_EXP_DEF     0
`define DIV_CNT_W       8

// fault pin output enable level while the pin is driven
`define FAULT_OE_DRIVE  1'b0

`endif

// ### hw/crc_readout_pkg.sv
// types shared by the signature readout port and the integrity checker
`default_nettype none
`include "crc_readout_defs.svh"

package crc_readout_pkg;

	// one signature word
	typedef logic [`SIG_W-1:0] sig_word_t;

	// parallel load source
	typedef enum logic {
		SRC_PRECOMP,
		SRC_SIGNATURE
	} load_src_t;

	// readout sequence
	typedef enum logic [1:0] {
		RD_EMPTY,
		RD_LOADED,
		RD_SHIFT,
		RD_DONE
	} readout_state_t;

endpackage : crc_readout_pkg

`default_nettype wire

// ### hw/check_if.sv
// carrier between the readout port and the integrity checker
`timescale 1ns/100ps
`default_nettype none

interface check_if;
	import crc_readout_pkg::*;

	sig_word_t precomp;     // expected signature
	sig_word_t signature;   // last computed signature
	logic      crc_error;   // sticky integrity fault

	modport check_side (input precomp, output signature, output crc_error);
	modport readout (output precomp, input signature, input crc_error);

endinterface : check_if

`default_nettype wire

// ### hw/crc_error_check.sv
// integrity checker running on the divided check clock tick
`timescale 1ns/100ps
`default_nettype none
`include "crc_readout_defs.svh"

module crc_error_check #(
	parameter int unsigned DIV_EXP = `DIV_EXP_DEF
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        sys_rst,
	// result of the signature engine
	input  wire crc_readout_pkg::sig_word_t  computed_sig,
	input  wire logic                        sig_valid,
	input  wire logic                        config_upset,
	// towards the readout port
	check_if.check_side                      bus
);
	import crc_readout_pkg::*;

	localparam logic [`DIV_CNT_W-1:0] DIV_MASK =
		`DIV_CNT_W'((1 << DIV_EXP) - 1);

	if (DIV_EXP > `DIV_EXP_MAX) begin : g_bad_div
		$error("DIV_EXP above the supported divider range");
	end

	logic [`DIV_CNT_W-1:0] div_cnt_reg;
	logic                  tick;
	logic                  pending_reg;
	sig_word_t             pend_sig_reg;
	sig_word_t             signature_reg;
	logic                  error_reg;

	// divide sys_clk by two to the power n for the check tick
	assign tick = (div_cnt_reg == DIV_MASK);
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			div_cnt_reg <= '0;
		else if (tick)
			div_cnt_reg <= '0;
		else
			div_cnt_reg <= div_cnt_reg + `DIV_CNT_W'(1);
	end

	// hold an engine result until the next check tick; a new one wins
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pending_reg  <= 1'b0;
			pend_sig_reg <= `SIG_RST;
		end else if (sig_valid) begin
			pending_reg  <= 1'b1;
			pend_sig_reg <= computed_sig;
		end else if (tick) begin
			pending_reg  <= 1'b0;
		end
	end

	// signature register follows the check clock, not the readout clock
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			signature_reg <= `SIG_RST;
		else if (tick && pending_reg)
			signature_reg <= pend_sig_reg;
	end

	// fault needs both an upset and a mismatch; only reconfig clears it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			error_reg <= 1'b0;
		else if (tick && pending_reg && config_upset &&
			pend_sig_reg != bus.precomp)
			error_reg <= 1'b1;
	end

	assign bus.signature = signature_reg;
	assign bus.crc_error = error_reg;

	a_err_cause: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		$rose(error_reg) |-> $past(tick) && $past(config_upset))
		else $error("fault rose without a check tick and upset");

	a_err_sticky: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		error_reg |=> error_reg)
		else $error("fault flag dropped without reset");

	a_sig_update: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		!tick |=> $stable(signature_reg))
		else $error("signature changed off the check tick");

endmodule : crc_error_check

`default_nettype wire

// ### hw/crc_readout_port.sv
// signature readout shift register and integrity fault pin
`timescale 1ns/100ps
`default_nettype none
`include "crc_readout_defs.svh"


module crc_readout_port #(
	parameter int unsigned DIV_EXP = `DIV_EXP_DEF
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        sys_rst,
	// readout port driven by core logic
	input  wire logic                        readout_clk,
	input  wire logic                        shift_n_load,
	input  wire logic                        load_src,
	output logic                             sig_serial_out,
	output logic                             word_done,
	// signature sources inside the device
	input  wire crc_readout_pkg::sig_word_t  precomputed_crc,
	input  wire crc_readout_pkg::sig_word_t  computed_sig,
	input  wire logic                        sig_valid,
	input  wire logic                        config_upset,
	// integrity fault pin
	output logic                             fault_pin_o,
	output logic                             fault_pin_oe_n,
	input  wire logic                        fault_pin_i,
	output logic                             fault_core
);
	import crc_readout_pkg::*;

	// pick the parallel load word
	function automatic sig_word_t select_source(
		input load_src_t src,
		input sig_word_t precomp,
		input sig_word_t signature
	);
		select_source = (src == SRC_SIGNATURE) ? signature : precomp;
	endfunction : select_source

	check_if chk ();

	// checker on the divided system clock tick
	crc_error_check #(
		.DIV_EXP (DIV_EXP)
	) u_check (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.computed_sig (computed_sig),
		.sig_valid    (sig_valid),
		.config_upset (config_upset),
		.bus          (chk.check_side)
	);

	assign chk.precomp = precomputed_crc;

	logic [2:0]                rclk_sync_reg;
	logic [1:0]                snl_sync_reg;
	logic [1:0]                src_sync_reg;
	logic [1:0]                fault_sync_reg;
	logic                      rclk_rise;
	logic                      snl;
	load_src_t                 src;
	sig_word_t                 load_word;
	sig_word_t                 shreg_reg;
	sig_word_t                 shreg_next;
	logic                      serial_next;
	logic [`SHIFT_CNT_W-1:0]   shift_cnt_reg;
	logic [1:0]                low_cnt_reg;
	readout_state_t            state_reg;
	readout_state_t            state_next;
	logic                      word_done_reg;

	// core-side pins cross in on two flops before anything reads them
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rclk_sync_reg <= 3'h0;
			snl_sync_reg  <= 2'h3;
			src_sync_reg  <= 2'h0;
		end else begin
			rclk_sync_reg <= {rclk_sync_reg[1:0], readout_clk};
			snl_sync_reg  <= {snl_sync_reg[0], shift_n_load};
			src_sync_reg  <= {src_sync_reg[0], load_src};
		end
	end

	// controls share the clock's delay, so they line up with its edge
	assign rclk_rise = rclk_sync_reg[1] & ~rclk_sync_reg[2];
	assign snl       = snl_sync_reg[1];
	assign src       = load_src_t'(src_sync_reg[1]);

	// source select only matters on a load edge
	assign load_word = select_source(src, chk.precomp,
		chk.signature);

	// next shift register contents on a readout edge
	always_comb begin
		shreg_next  = shreg_reg;
		serial_next = sig_serial_out;
		if (rclk_rise) begin
			if (!snl) begin
				shreg_next  = load_word;
				serial_next = load_word[0];
			end else begin
				shreg_next  = {1'b0, shreg_reg[`SIG_W-1:1]};
				serial_next = shreg_reg[1];
			end
		end
	end

	// readout register, touched only on readout edges
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			shreg_reg <= `SIG_RST;
		else
			shreg_reg <= shreg_next;
	end

	// serial output straight from a flop
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			sig_serial_out <= 1'b0;
		else
			sig_serial_out <= serial_next;
	end

	// shifts since the last load, saturating once the word is out
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			shift_cnt_reg <= '0;
		else if (rclk_rise && !snl)
			shift_cnt_reg <= '0;
		else if (rclk_rise && shift_cnt_reg != `SHIFT_CNT_W'(`SHIFT_TAIL))
			shift_cnt_reg <= shift_cnt_reg + `SHIFT_CNT_W'(1);
	end

	// consecutive low-control edges; a shorter burst still loads here
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			low_cnt_reg <= 2'h0;
		else if (rclk_rise && snl)
			low_cnt_reg <= 2'h0;
		else if (rclk_rise && low_cnt_reg != 2'h3)
			low_cnt_reg <= low_cnt_reg + 2'h1;
	end

	// readout sequence
	always_comb begin
		state_next = state_reg;
		if (rclk_rise) begin
			unique case (state_reg)
				RD_EMPTY:
					if (!snl)
						state_next = RD_LOADED;
				RD_LOADED:
					if (snl)
						state_next = RD_SHIFT;
				RD_SHIFT, RD_DONE: begin
					if (!snl)
						state_next = RD_LOADED;
					else if (shift_cnt_reg >=
						`SHIFT_CNT_W'(`SHIFT_TAIL - 1))
						state_next = RD_DONE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			state_reg <= RD_EMPTY;
		else
			state_reg <= state_next;
	end

	// whole word has been presented on the serial output
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			word_done_reg <= 1'b0;
		else
			word_done_reg <= (state_next == RD_DONE);
	end

	assign word_done = word_done_reg;

	// fault pin is always driven; core reads it back through the pad
	assign fault_pin_o    = chk.crc_error;
	assign fault_pin_oe_n = `FAULT_OE_DRIVE;

	// pad return is a foreign level, so it is synchronised
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			fault_sync_reg <= 2'h0;
		else
			fault_sync_reg <= {fault_sync_reg[0], fault_pin_i};
	end

	assign fault_core = fault_sync_reg[1];

	// helpers for the checks below
	logic shreg_bit1;
	logic load_bit0;
	assign shreg_bit1 = shreg_reg[1];
	assign load_bit0  = load_word[0];

	// checks on the readout path, all on the system clock
	a_edge_only: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		!rclk_rise |=> $stable(shreg_reg) && $stable(sig_serial_out))
		else $error("readout register moved without a readout edge");

	a_load_precomp: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && !snl && src == SRC_PRECOMP
		|=> shreg_reg == $past(chk.precomp))
		else $error("select 0 did not load the pre-computed value");

	a_load_sig: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && !snl && src == SRC_SIGNATURE
		|=> shreg_reg == $past(chk.signature))
		else $error("select 1 did not load the signature");

	a_shift_move: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && snl |=> shreg_reg == ($past(shreg_reg) >> 1))
		else $error("shift edge did not move the register by one");

	// zeros enter at the top, so shifting past the word reads zeros
	a_tail_zero: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && snl |=> !shreg_reg[`SIG_W-1])
		else $error("shift did not fill the top bit with zero");

	a_src_ignored: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && snl |=> sig_serial_out == $past(shreg_bit1))
		else $error("shift edge output not the next register bit");

	a_load_first: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && !snl |=> sig_serial_out == $past(load_bit0))
		else $error("first bit not presented after a load");

	// a load restarts the word whatever state the sequence was in
	a_done_clear: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && !snl |=> !word_done_reg)
		else $error("done flag survived a load edge");

	a_load_state: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		rclk_rise && !snl |=> state_reg == RD_LOADED)
		else $error("load edge did not restart the sequence");

	a_done_count: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		$rose(word_done_reg)
		|-> shift_cnt_reg == `SHIFT_CNT_W'(`SHIFT_TAIL))
		else $error("word done without 31 shifts");

	a_fault_hold: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		fault_pin_o |=> fault_pin_o && !fault_pin_oe_n)
		else $error("fault pin dropped or released");

	// pad return reaches the core after exactly two flops
	a_pad_sync: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		$rose(fault_pin_i) |-> ##2 fault_core)
		else $error("fault readback late or missing");

	c_load_two: cover property (@(posedge sys_clk) disable iff (sys_rst)
		rclk_rise && !snl && low_cnt_reg == 2'h1);

	c_word_out: cover property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(word_done_reg));

	c_sig_load: cover property (@(posedge sys_clk) disable iff (sys_rst)
		rclk_rise && !snl && src == SRC_SIGNATURE);

	c_shift_src: cover property (@(posedge sys_clk) disable iff (sys_rst)
		rclk_rise && snl && src == SRC_SIGNATURE);

	c_fault: cover property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(fault_pin_o));

endmodule : crc_readout_port

`default_nettype wire

// ### sim/core_reader_model.sv
// core logic side: walks the readout port and asks for reconfiguration
`timescale 1ns/100ps
`default_nettype none

module core_reader_model
	import crc_readout_pkg::*;
(
	// clock
	input  wire logic  sys_clk,
	// command from the bench
	input  wire logic  start,
	input  wire logic  src,
	input  wire logic  slow,
	// readout port of the device
	output logic       readout_clk,
	output logic       shift_n_load,
	output logic       load_src,
	input  wire logic  sig_serial_out,
	// collected word
	output sig_word_t  word,
	output logic       done,
	// fault handling
	input  wire logic  fault_core,
	output logic       reconfig_request_n
);
	int hp;

	// every change lands just after a system clock edge
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wait_cyc

	// phases of at least three system clocks, or edges are lost
	task automatic pulse_clk;
		readout_clk = 1'b1;
		wait_cyc(hp);
		readout_clk = 1'b0;
		wait_cyc(hp);
	endtask : pulse_clk

	// load twice, then 31 shifts; clock stands low between frames
	initial begin
		readout_clk = 1'b0;
		shift_n_load = 1'b1;
		load_src = 1'b0;
		word = '0;
		done = 1'b0;
		hp = 4;
		forever begin
			@(posedge sys_clk);
			if (start === 1'b1) begin
				hp = slow ? 6 : 4;
				#1;
				shift_n_load = 1'b0;
				load_src = src;
				wait_cyc(hp);
				pulse_clk();
				pulse_clk();
				word[0] = sig_serial_out;
				shift_n_load = 1'b1;
				load_src = ~src;
				wait_cyc(hp);
				for (int i = 1; i < 32; i++) begin
					pulse_clk();
					word[i] = sig_serial_out;
				end
				done = 1'b1;
				wait_cyc(1);
				done = 1'b0;
			end
		end
	end

	// trust the fault pin, not the word, and request a reload
	initial begin
		reconfig_request_n = 1'b1;
		forever begin
			@(posedge sys_clk);
			if (fault_core === 1'b1) begin
				#1;
				reconfig_request_n = 1'b0;
				wait_cyc(4);
				reconfig_request_n = 1'b1;
			end
		end
	end

endmodule : core_reader_model

`default_nettype wire

// ### sim/crc_signature_readout_port_bench.sv
// self-checking bench for the signature readout port
`timescale 1ns/100ps
`default_nettype none

module crc_signature_readout_port_bench
	import crc_readout_pkg::*;
;
	localparam int DIV = 2;
	localparam int FBOUND = (1 << DIV) + 3;

	logic       sys_clk, sys_rst, readout_clk, shift_n_load, load_src;
	logic       sig_serial_out, word_done, sig_valid, config_upset;
	logic       fault_pin_o, fault_pin_oe_n, fault_pin_i, fault_core;
	logic       start, src, slow, rd_done, reconfig_request_n;
	sig_word_t  precomputed_crc, computed_sig, word;
	sig_word_t  exp_q[$];
	int         checks, n_mismatch, cyc, k;

	// pin wire: pulled low when nobody drives it
	assign fault_pin_i = (fault_pin_oe_n === 1'b0) ? fault_pin_o : 1'b0;

	crc_readout_port #(.DIV_EXP(DIV)) dut_u (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.readout_clk(readout_clk), .shift_n_load(shift_n_load),
		.load_src(load_src), .sig_serial_out(sig_serial_out),
		.word_done(word_done), .precomputed_crc(precomputed_crc),
		.computed_sig(computed_sig), .sig_valid(sig_valid),
		.config_upset(config_upset), .fault_pin_o(fault_pin_o),
		.fault_pin_oe_n(fault_pin_oe_n), .fault_pin_i(fault_pin_i),
		.fault_core(fault_core));

	core_reader_model core_u (
		.sys_clk(sys_clk), .start(start), .src(src), .slow(slow),
		.readout_clk(readout_clk), .shift_n_load(shift_n_load),
		.load_src(load_src), .sig_serial_out(sig_serial_out),
		.word(word), .done(rd_done), .fault_core(fault_core),
		.reconfig_request_n(reconfig_request_n));

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	task automatic check(input sig_word_t seen, input sig_word_t exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// hang guard, far above the longest expected run
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	// watcher: oldest note against each finished word
	always @(posedge sys_clk) begin
		if (rd_done === 1'b1 && exp_q.size() > 0) begin
			check(word, exp_q.pop_front());
			check(sig_word_t'(word_done), 32'h1);
		end
	end

	task automatic read_word(input logic s, input logic sl, input sig_word_t e);
		exp_q.push_back(e);
		@(posedge sys_clk);
		#1;
		src = s;
		slow = sl;
		start = 1'b1;
		@(posedge sys_clk);
		#1;
		start = 1'b0;
		k = 0;
		while (rd_done !== 1'b1 && k < 3000) begin
			@(posedge sys_clk);
			k++;
		end
		@(posedge sys_clk);
		#1;
	endtask : read_word

	// one result from the engine, then a bounded wait on the fault
	task automatic post_sig(input sig_word_t v, input logic up, input logic e);
		@(posedge sys_clk);
		#1;
		computed_sig = v;
		config_upset = up;
		sig_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		sig_valid = 1'b0;
		k = 0;
		while (fault_pin_o !== 1'b1 && k < FBOUND) begin
			@(posedge sys_clk);
			k++;
		end
		#1;
		check(sig_word_t'(fault_pin_o), sig_word_t'(e));
	endtask : post_sig

	initial begin
		{sys_rst, sig_valid, config_upset, start, src, slow} = 6'h20;
		precomputed_crc = '0;
		computed_sig = '0;
		void'($urandom(32'hac4d));
		repeat (16) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		check(sig_word_t'(sig_serial_out), 32'h0);
		check(sig_word_t'(word_done), 32'h0);
		// pre-computed source, prompt and slow readout clocks
		for (int i = 0; i < 2; i++) begin
			precomputed_crc = $urandom;
			read_word(1'b0, i[0], precomputed_crc);
		end
		// mismatch alone leaves the fault clear; word still readable
		computed_sig = $urandom;
		post_sig(~precomputed_crc, 1'b0, 1'b0);
		read_word(1'b1, 1'b0, ~precomputed_crc);
		// upset with a matching signature sets no fault
		post_sig(precomputed_crc, 1'b1, 1'b0);
		read_word(1'b1, 1'b1, precomputed_crc);
		// upset with a mismatch raises the pin on the check clock
		post_sig(precomputed_crc ^ 32'h0000_0100, 1'b1, 1'b1);
		check(sig_word_t'(fault_pin_oe_n), 32'h0);
		repeat (3) @(posedge sys_clk);
		#1;
		check(sig_word_t'(fault_core), 32'h1);
		k = 0;
		while (reconfig_request_n !== 1'b0 && k < 20) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		check(sig_word_t'(reconfig_request_n), 32'h0);
		// reload stands in for reconfiguration; fault must clear
		sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		check(sig_word_t'(fault_pin_o), 32'h0);
		config_upset = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		precomputed_crc = $urandom;
		read_word(1'b0, 1'b0, precomputed_crc);
		check(sig_word_t'(exp_q.size()), 32'h0);
		close_out();
	end

endmodule : crc_signature_readout_port_bench

`default_nettype wire
